/* File: ascc_pkg.sv */
// package: register map, field positions and sequencing constants
`default_nettype none
package ascc_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] ADDR_CTRL1  = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK   = 8'h08;
  localparam logic [7:0] ADDR_RESULT = 8'h0c;
  localparam logic [7:0] ADDR_SAMPT  = 8'h10;
  localparam logic [7:0] ADDR_CTRL2  = 8'h14;
  // control register 1 field positions
  localparam int unsigned POS_ON    = 15;
  localparam int unsigned POS_SIDL  = 13;
  localparam int unsigned POS_FORM  = 8;
  localparam int unsigned POS_TRIG  = 5;
  localparam int unsigned POS_SIM   = 3;
  localparam int unsigned POS_AUTO  = 2;
  localparam int unsigned POS_ACQ   = 1;
  localparam int unsigned POS_DONE  = 0;
  // implemented bits of control register 1
  localparam logic [15:0] CTRL1_WMASK = 16'ha3ef;
  localparam logic [15:0] CTRL1_RST   = 16'h0000;
  // result layouts
  localparam logic [1:0] FORM_UINT  = 2'h0;
  localparam logic [1:0] FORM_SINT  = 2'h1;
  localparam logic [1:0] FORM_SFRAC = 2'h3;
  // conversion trigger codes
  localparam logic [2:0] TRIG_SW    = 3'h0;
  localparam logic [2:0] TRIG_TMR3  = 3'h2;
  localparam logic [2:0] TRIG_PWM   = 3'h3;
  localparam logic [2:0] TRIG_AUTO  = 3'h7;
  // interrupt status bit positions
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_CONV = 1;
  // converter busy time per channel in clock cycles
  localparam logic [3:0] CONV_CYCLES   = 4'hc;
  localparam logic [7:0] SAMPT_RST     = 8'h03;
  localparam int unsigned RES_DEPTH    = 4;
  // user-side signals that travel together
  typedef struct packed {
    logic       tmr3_match;
    logic       pwm_interval;
    logic       idle;
  } ascc_events_t;
  typedef struct packed {
    logic       sample;
    logic [3:0] hold_ch;
    logic       convert;
    logic [1:0] ch;
  } ascc_afe_t;
endpackage
`default_nettype wire

/* File: ascc_result_mem.sv */
// result memory: one formatted word per sample/hold channel
`default_nettype none
module ascc_result_mem (
  input  wire logic        clk_i,
  input  wire logic        we_i,
  input  wire logic [1:0]  waddr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic [1:0]  raddr_i,
  output logic      [15:0] rdata_o
);
  logic [15:0] mem_reg [ascc_pkg::RES_DEPTH];

  // write port; storage needs no reset
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  // registered read port
  always_ff @(posedge clk_i) begin
    rdata_o <= mem_reg[raddr_i];
  end
endmodule
`default_nettype wire

/* File: ascc_top.sv */
// converter sample/convert control with apb registers and interrupt
`default_nettype none
module ascc_top (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [7:0]             paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  input  wire ascc_pkg::ascc_events_t evt_i,
  input  wire logic [9:0]             conv_data_i,
  output ascc_pkg::ascc_afe_t         afe_o,
  output logic                        irq_o
);
  typedef enum logic [1:0] {
    ST_OFF    = 2'b00,
    ST_IDLE   = 2'b01,
    ST_SAMPLE = 2'b10,
    ST_CONV   = 2'b11
  } ascc_state_t;

  // format a raw 10-bit code according to the layout field
  function automatic logic [15:0] fmt(input logic [1:0] f,
                                      input logic [9:0] d);
    case (f)
      ascc_pkg::FORM_SFRAC: fmt = {~d[9], d[8:0], 6'h00};
      ascc_pkg::FORM_SINT:  fmt = {{7{~d[9]}}, d[8:0]};
      ascc_pkg::FORM_UINT:  fmt = {6'h00, d};
      default:              fmt = {6'h00, d};
    endcase
  endfunction

  // reset release through two flip-flops
  logic rst_s1_reg, rst_n;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // event inputs come from other logic on this clock, no sync needed
  logic [15:0] ctrl_reg, ctrl_next;
  logic [1:0]  ctrl2_reg, ctrl2_next;
  logic [7:0]  sampt_reg, sampt_next;
  logic [1:0]  stat_reg, stat_next, mask_reg, mask_next;
  logic [31:0] prdata_next, prdata_reg;
  ascc_state_t st_reg, st_next;
  logic [7:0]  scnt_reg, scnt_next;
  logic [3:0]  ccnt_reg, ccnt_next;
  logic [1:0]  ch_reg, ch_next;
  logic [1:0]  last_ch;
  logic        sim_eff, run, trig, conv_end, wr, rd, acq_wr_clr;
  logic        mem_we;
  logic [15:0] mem_rdata;

  assign wr = psel_i & penable_i & pwrite_i;
  assign rd = psel_i & penable_i & ~pwrite_i;
  assign pready_o  = 1'b1;                          // zero wait states
  assign pslverr_o = 1'b0;

  wire logic on_b   = ctrl_reg[ascc_pkg::POS_ON];
  wire logic sidl_b = ctrl_reg[ascc_pkg::POS_SIDL];
  wire logic auto_b = ctrl_reg[ascc_pkg::POS_AUTO];
  wire logic acq_b  = ctrl_reg[ascc_pkg::POS_ACQ];
  wire logic [2:0] trig_f = ctrl_reg[ascc_pkg::POS_TRIG +: 3];

  // converter may run only when on and not halted by idle
  assign run = on_b & ~(sidl_b & evt_i.idle);
  // simultaneous only with more than one channel selected
  assign sim_eff = ctrl_reg[ascc_pkg::POS_SIM] & (ctrl2_reg != 2'h0);
  assign last_ch = (ctrl2_reg[1]) ? 2'h3 : ctrl2_reg;
  assign acq_wr_clr = wr && paddr_i == ascc_pkg::ADDR_CTRL1
                      && !pwdata_i[ascc_pkg::POS_ACQ] && acq_b;

  // selection of the event that ends sampling; reserved codes never fire
  always_comb begin
    case (trig_f)
      ascc_pkg::TRIG_AUTO: trig = (scnt_reg == sampt_reg);
      ascc_pkg::TRIG_PWM:  trig = evt_i.pwm_interval;
      ascc_pkg::TRIG_TMR3: trig = evt_i.tmr3_match;
      ascc_pkg::TRIG_SW:   trig = acq_wr_clr;
      default:             trig = 1'b0;
    endcase
  end

  // sequencer: sample, then convert each channel in turn
  always_comb begin
    st_next   = st_reg;
    scnt_next = scnt_reg;
    ccnt_next = ccnt_reg;
    ch_next   = ch_reg;
    conv_end  = 1'b0;
    mem_we    = 1'b0;
    if (!run) begin
      st_next = ST_OFF;
    end else begin
      case (st_reg)
        ST_OFF: begin
          st_next = ST_IDLE;
        end
        ST_IDLE: begin
          if (acq_b) begin
            st_next   = ST_SAMPLE;
            scnt_next = 8'h00;
          end
        end
        ST_SAMPLE: begin
          scnt_next = scnt_reg + 8'h01;
          if (trig) begin
            st_next   = ST_CONV;
            ccnt_next = 4'h0;
            ch_next   = 2'h0;
          end
        end
        ST_CONV: begin
          ccnt_next = ccnt_reg + 4'h1;
          if (ccnt_reg == ascc_pkg::CONV_CYCLES - 4'h1) begin
            mem_we    = 1'b1;
            ccnt_next = 4'h0;
            if (ch_reg == last_ch) begin
              conv_end  = 1'b1;
              st_next   = auto_b ? ST_SAMPLE : ST_IDLE;
              scnt_next = 8'h00;
            end else begin
              ch_next = ch_reg + 2'h1;
            end
          end
        end
        default: st_next = ST_OFF;
      endcase
    end
  end

  // register writes, hardware set/clear of acquire and done flags
  always_comb begin
    ctrl_next  = ctrl_reg;
    ctrl2_next = ctrl2_reg;
    sampt_next = sampt_reg;
    mask_next  = mask_reg;
    stat_next  = stat_reg;
    if (wr) begin
      case (paddr_i)
        ascc_pkg::ADDR_CTRL1: begin
          // done is clear-only from software
          ctrl_next = (pwdata_i[15:0] & ascc_pkg::CTRL1_WMASK
                       & ~16'h0001)
                    | (ctrl_reg & pwdata_i[15:0] & 16'h0001);
        end
        ascc_pkg::ADDR_CTRL2: ctrl2_next = pwdata_i[1:0];
        ascc_pkg::ADDR_SAMPT: sampt_next = pwdata_i[7:0];
        ascc_pkg::ADDR_MASK:  mask_next  = pwdata_i[1:0];
        default: ;
      endcase
    end
    // read clears only the bits already handed out in prdata, so an
    // event that lands during the access phase is not lost
    if (rd && paddr_i == ascc_pkg::ADDR_STATUS) begin
      stat_next = stat_reg & ~prdata_reg[1:0];
    end
    if (mem_we) begin
      stat_next[ascc_pkg::IRQ_CONV] = 1'b1;          // set beats clear
    end
    if (st_reg == ST_SAMPLE && trig) begin
      ctrl_next[ascc_pkg::POS_ACQ] = 1'b0;
    end
    if (conv_end) begin
      ctrl_next[ascc_pkg::POS_DONE] = 1'b1;
      stat_next[ascc_pkg::IRQ_DONE] = 1'b1;
      if (auto_b) begin
        ctrl_next[ascc_pkg::POS_ACQ] = 1'b1;
      end
    end
    // follow the new on bit so on and acquire may be set in one write
    if (!ctrl_next[ascc_pkg::POS_ON]) begin
      ctrl_next[ascc_pkg::POS_ACQ] = 1'b0;
    end
  end

  // read data mux; unmapped offsets read zero
  always_comb begin
    prdata_next = 32'h0000_0000;
    case (paddr_i)
      ascc_pkg::ADDR_CTRL1:  prdata_next[15:0] = ctrl_reg;
      ascc_pkg::ADDR_CTRL2:  prdata_next[1:0]  = ctrl2_reg;
      ascc_pkg::ADDR_SAMPT:  prdata_next[7:0]  = sampt_reg;
      ascc_pkg::ADDR_STATUS: prdata_next[1:0]  = stat_reg;
      ascc_pkg::ADDR_MASK:   prdata_next[1:0]  = mask_reg;
      ascc_pkg::ADDR_RESULT: prdata_next[15:0] = mem_rdata;
      default: ;
    endcase
  end

  // control and sequencer state registers; controls reset to zero except sample time, which loads SAMPT_RST
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg  <= ascc_pkg::CTRL1_RST;
      ctrl2_reg <= 2'h0;
      sampt_reg <= ascc_pkg::SAMPT_RST;
      stat_reg  <= 2'h0;
      mask_reg  <= 2'h0;
      st_reg    <= ST_OFF;
      scnt_reg  <= 8'h00;
      ccnt_reg  <= 4'h0;
      ch_reg    <= 2'h0;
    end else begin
      ctrl_reg  <= ctrl_next;
      ctrl2_reg <= ctrl2_next;
      sampt_reg <= sampt_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      st_reg    <= st_next;
      scnt_reg  <= scnt_next;
      ccnt_reg  <= ccnt_next;
      ch_reg    <= ch_next;
    end
  end

  // prdata from a flop: valid in the access phase since setup set it
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end
  assign prdata_o = prdata_reg;
  assign irq_o = |(stat_reg & mask_reg);

  // result store; read address fixed at channel 0
  ascc_result_mem u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .waddr_i (ch_reg),
    .wdata_i (fmt(ctrl_reg[ascc_pkg::POS_FORM +: 2], conv_data_i)),
    .raddr_i (2'h0),                  // result register shows channel 0
    .rdata_o (mem_rdata)
  );

  // analog front end: holds open during sampling
  always_comb begin
    afe_o.sample  = (st_reg == ST_SAMPLE);
    afe_o.convert = (st_reg == ST_CONV);
    afe_o.ch      = ch_reg;
    afe_o.hold_ch = 4'h0;
    if (st_reg == ST_SAMPLE) begin
      if (sim_eff) begin
        afe_o.hold_ch = ctrl2_reg[1] ? 4'hf : 4'h3;
      end else begin
        afe_o.hold_ch = 4'h1;
      end
    end else if (st_reg == ST_CONV && !sim_eff) begin
      afe_o.hold_ch = 4'h1 << ch_reg;
    end
  end

  // sequencer and register checks, sampled on the system clock
  AST_OFF_IDLE: assert property (@(posedge clk_i) disable iff (!rst_n)
    !run |=> st_reg == ST_OFF) else $error("not off");
  AST_HALT: assert property (@(posedge clk_i) disable iff (!rst_n)
    on_b && sidl_b && evt_i.idle |=> !afe_o.convert)
    else $error("runs in idle");
  AST_DONE_SET: assert property (@(posedge clk_i) disable iff (!rst_n)
    conv_end |=> ctrl_reg[ascc_pkg::POS_DONE]) else $error("done");
  // done may only drop on a software write of zero
  AST_DONE_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n)
    ctrl_reg[ascc_pkg::POS_DONE] && !(wr && paddr_i == ascc_pkg::ADDR_CTRL1
    && !pwdata_i[ascc_pkg::POS_DONE]) |=> ctrl_reg[ascc_pkg::POS_DONE])
    else $error("done dropped");
  AST_AUTO: assert property (@(posedge clk_i) disable iff (!rst_n)
    conv_end && auto_b && ctrl_next[ascc_pkg::POS_ON]
    |=> st_reg == ST_SAMPLE && acq_b) else $error("no restart");
  AST_TRIG7: assert property (@(posedge clk_i) disable iff (!rst_n)
    st_reg == ST_SAMPLE && run && trig_f == ascc_pkg::TRIG_AUTO
    && scnt_reg == sampt_reg |=> st_reg == ST_CONV)
    else $error("counter");
  // each selected event ends sampling on the next edge
  AST_TMR3: assert property (@(posedge clk_i) disable iff (!rst_n)
    st_reg == ST_SAMPLE && run && trig_f == ascc_pkg::TRIG_TMR3
    && evt_i.tmr3_match |=> st_reg == ST_CONV) else $error("timer3");
  AST_PWM: assert property (@(posedge clk_i) disable iff (!rst_n)
    st_reg == ST_SAMPLE && run && trig_f == ascc_pkg::TRIG_PWM
    && evt_i.pwm_interval |=> st_reg == ST_CONV) else $error("pwm");
  AST_SWCLR: assert property (@(posedge clk_i) disable iff (!rst_n)
    st_reg == ST_SAMPLE && run && trig_f == ascc_pkg::TRIG_SW
    && acq_wr_clr |=> st_reg == ST_CONV) else $error("sw clear");
  AST_ACQ_END: assert property (@(posedge clk_i) disable iff (!rst_n)
    st_reg == ST_SAMPLE && run && trig |=> !acq_b)
    else $error("acquire kept");
  AST_START: assert property (@(posedge clk_i) disable iff (!rst_n)
    st_reg == ST_IDLE && run && acq_b |=> st_reg == ST_SAMPLE)
    else $error("no start");
  AST_IDLE_WAIT: assert property (@(posedge clk_i) disable iff (!rst_n)
    st_reg == ST_IDLE && run && !acq_b |=> st_reg == ST_IDLE)
    else $error("early start");
  AST_RSVD: assert property (@(posedge clk_i) disable iff (!rst_n)
    trig_f[2:1] == 2'b10 |-> !trig) else $error("reserved");
  AST_SIM: assert property (@(posedge clk_i) disable iff (!rst_n)
    ctrl2_reg == 2'h0 |-> !sim_eff) else $error("sim");
  AST_SIM_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n)
    st_reg == ST_SAMPLE && sim_eff && ctrl2_reg[1] |-> afe_o.hold_ch == 4'hf)
    else $error("sim hold");
  AST_UNIMP: assert property (@(posedge clk_i) disable iff (!rst_n)
    (ctrl_reg & ~ascc_pkg::CTRL1_WMASK) == 16'h0000)
    else $error("unimpl bit");
  AST_IRQ: assert property (@(posedge clk_i) disable iff (!rst_n)
    ##1 irq_o == |($past(stat_next) & $past(mask_next)))
    else $error("irq");
  // scenarios worth seeing in every run
  COV_SW: cover property (@(posedge clk_i) st_reg == ST_SAMPLE
    && trig_f == ascc_pkg::TRIG_SW && trig);
  COV_AUTO: cover property (@(posedge clk_i) conv_end && auto_b);
  COV_SIM: cover property (@(posedge clk_i) afe_o.hold_ch == 4'hf);
  COV_TMR3: cover property (@(posedge clk_i) st_reg == ST_SAMPLE
    && trig_f == ascc_pkg::TRIG_TMR3 && trig);
  COV_HALT: cover property (@(posedge clk_i) on_b && sidl_b && evt_i.idle);
endmodule
`default_nettype wire

/* File: ascc_conv_model.sv */
// behavioural converter front end that answers the conversion requests
`default_nettype none
module ascc_conv_model (
  input  wire logic                clk_i,
  input  wire ascc_pkg::ascc_afe_t afe_i,
  input  wire logic [9:0]          code_i,
  output logic      [9:0]          data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] junk_reg = 10'h3ff;
  // outside a conversion the line toggles, so a stale sample is caught
  always_ff @(posedge clk_i) begin
    junk_reg <= ~junk_reg;
  end
  assign data_o = afe_i.convert ? code_i : (~code_i ^ junk_reg);
endmodule
`default_nettype wire

/* File: adc_sample_convert_control_bench.sv */
// self-checking bench: apb accesses, triggers, layouts and interrupt
`default_nettype none
module adc_sample_convert_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0]  A_C1 = ascc_pkg::ADDR_CTRL1;
  localparam logic [15:0] B_ON = 16'h1 << ascc_pkg::POS_ON;
  localparam logic [15:0] B_AQ = 16'h1 << ascc_pkg::POS_ACQ;
  logic                   clk_i     = 1'b0;
  logic                   rst_n_i   = 1'b0;
  logic                   psel_i    = 1'b0;
  logic                   penable_i = 1'b0;
  logic                   pwrite_i  = 1'b0;
  logic [7:0]             paddr_i   = 8'h00;
  logic [31:0]            pwdata_i  = 32'h0;
  logic [31:0]            prdata_o;
  logic                   pready_o;
  logic                   pslverr_o;
  logic                   irq_o;
  ascc_pkg::ascc_events_t evt_i     = '0;
  ascc_pkg::ascc_afe_t    afe_o;
  logic [9:0]             conv_data_i;
  logic [9:0]             code      = 10'h2a5;
  logic [31:0]            rd;
  logic                   err;
  int                     bad_count = 0;
  int                     checked   = 0;
  int                     cycles    = 0;
  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;
  ascc_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .evt_i(evt_i), .conv_data_i(conv_data_i),
    .afe_o(afe_o), .irq_o(irq_o));
  ascc_conv_model u_conv (.clk_i(clk_i), .afe_i(afe_o), .code_i(code),
    .data_o(conv_data_i));
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; starts on a fresh edge so no signal is set twice
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
    chk("slverr", {31'h0, err}, 32'h0);
  endtask
  task automatic pulse(input int which);
    @(posedge clk_i);
    if (which == 0) evt_i.tmr3_match <= 1'b1;
    else evt_i.pwm_interval <= 1'b1;
    @(posedge clk_i);
    evt_i.tmr3_match   <= 1'b0;
    evt_i.pwm_interval <= 1'b0;
  endtask
  // poll the done flag with a bounded number of reads
  task automatic wait_done(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++) begin
      apb(1'b0, A_C1, 32'h0);
      ok = (rd[0] === 1'b1);
    end
  endtask
  // start sampling, then fire the event that the trigger code selects
  task automatic conv(input logic [15:0] cfg, input logic [2:0] trig);
    logic [15:0] v;
    v = cfg | (16'(trig) << ascc_pkg::POS_TRIG);
    apb(1'b1, A_C1, {16'h0, v | B_AQ});
    // give the sequencer time to reach sampling before any event
    repeat (2) @(posedge clk_i);
    if (trig == ascc_pkg::TRIG_TMR3) pulse(0);
    if (trig == ascc_pkg::TRIG_PWM) pulse(1);
    if (trig == ascc_pkg::TRIG_SW) apb(1'b1, A_C1, {16'h0, v});
  endtask
  function automatic logic [15:0] fmt(input logic [1:0] f,
                                      input logic [9:0] d);
    case (f)
      ascc_pkg::FORM_SFRAC: fmt = {~d[9], d[8:0], 6'h00};
      ascc_pkg::FORM_SINT:  fmt = {{7{~d[9]}}, d[8:0]};
      default:              fmt = {6'h00, d};
    endcase
  endfunction
  // hang guard, well above the under a thousand cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    logic [2:0]  trigs [4];
    logic [1:0]  forms [3];
    logic [15:0] cfg;
    logic        ok;
    trigs = '{ascc_pkg::TRIG_SW, ascc_pkg::TRIG_TMR3, ascc_pkg::TRIG_PWM,
              ascc_pkg::TRIG_AUTO};
    forms = '{ascc_pkg::FORM_UINT, ascc_pkg::FORM_SINT, ascc_pkg::FORM_SFRAC};
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rdchk("ctrl1 reset", A_C1, 32'h0);
    apb(1'b1, A_C1, 32'h5c10);
    rdchk("unused bits", A_C1, 32'h0);
    apb(1'b1, ascc_pkg::ADDR_MASK, 32'h1 << ascc_pkg::IRQ_DONE);
    // every trigger code against every layout, two sign cases
    for (int t = 0; t < 4; t++) begin
      for (int f = 0; f < 3; f++) begin
        code = t[0] ? 10'h155 : 10'h2a5;
        cfg = B_ON | (16'(forms[f]) << ascc_pkg::POS_FORM);
        chk("idle no sample", {31'h0, afe_o.sample}, 32'h0);
        conv(cfg, trigs[t]);
        wait_done(ok);
        chk("done", {31'h0, ok}, 32'h1);
        chk("irq up", {31'h0, irq_o}, 32'h1);
        rdchk("result", ascc_pkg::ADDR_RESULT,
              32'(fmt(forms[f], code)));
        apb(1'b0, ascc_pkg::ADDR_STATUS, 32'h0);
        @(posedge clk_i);
        chk("irq cleared", {31'h0, irq_o}, 32'h0);
        rdchk("ctrl1", A_C1, {16'h0, cfg | 16'h1
              | (16'(trigs[t]) << ascc_pkg::POS_TRIG)});
      end
    end
    // converter off: a trigger must not convert
    apb(1'b1, A_C1, 32'h0);
    conv(16'h0, ascc_pkg::TRIG_TMR3);
    repeat (40) @(posedge clk_i);
    apb(1'b0, A_C1, 32'h0);
    chk("off no done", {31'h0, rd[0]}, 32'h0);
    // idle with halt set stops, without halt it keeps converting
    evt_i.idle <= 1'b1;
    conv(B_ON | (16'h1 << ascc_pkg::POS_SIDL), ascc_pkg::TRIG_TMR3);
    repeat (40) @(posedge clk_i);
    apb(1'b0, A_C1, 32'h0);
    chk("idle halted", {31'h0, rd[0]}, 32'h0);
    conv(B_ON, ascc_pkg::TRIG_TMR3);
    wait_done(ok);
    chk("idle runs", {31'h0, ok}, 32'h1);
    evt_i.idle <= 1'b0;
    // auto restart sets acquire_active again by itself
    apb(1'b1, A_C1, 32'h0);
    conv(B_ON | 16'h4, ascc_pkg::TRIG_AUTO);
    wait_done(ok);
    chk("auto done", {31'h0, ok}, 32'h1);
    // read just after a conversion ends, while hardware holds acquire set
    for (int i = 0; i < 40 && afe_o.convert !== 1'b1; i++) @(posedge clk_i);
    for (int i = 0; i < 40 && afe_o.convert !== 1'b0; i++) @(posedge clk_i);
    apb(1'b0, A_C1, 32'h0);
    chk("auto restart", {31'h0, rd[1]}, 32'h1);
    // simultaneous hold pattern per channel count setting
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, A_C1, 32'h0);
      apb(1'b1, ascc_pkg::ADDR_CTRL2, 32'(c == 2 ? 3 : c));
      apb(1'b1, A_C1, {16'h0, B_ON | 16'h8 | B_AQ});
      // off to idle, idle to sampling, then look while sampling stands
      repeat (3) @(posedge clk_i);
      chk("hold", {28'h0, afe_o.hold_ch},
          c == 2 ? 32'hf : (c == 1 ? 32'h3 : 32'h1));
    end
    apb(1'b1, A_C1, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
